// File: hw/cocond_top.sv
// Clock output conditioning block with APB register access
`timescale 1ns/10ps
module cocond_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cocond_pkg::ADDR_W-1:0] paddr,
    input wire logic [cocond_pkg::DATA_W-1:0] pwdata,
    output logic [cocond_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_clock_in,
    output logic quad_phase_000,
    output logic quad_phase_090,
    output logic quad_phase_180,
    output logic quad_phase_270,
    output logic double_rate_out,
    output logic double_rate_out_inv,
    output logic divided_out,
    output logic synth_out,
    output logic synth_out_inv
);
    import cocond_pkg::*;

    function automatic logic [TICK_W-1:0] wrap_sub(
        input logic [TICK_W-1:0] a,
        input logic [TICK_W-1:0] m
    );
        wrap_sub = (a >= m) ? TICK_W'(a - m) : a;
    endfunction

    function automatic logic in_window(
        input logic [TICK_W-1:0] t,
        input logic [TICK_W-1:0] start,
        input logic [TICK_W-1:0] len,
        input logic [TICK_W-1:0] m
    );
        logic [TICK_W-1:0] rel;
        rel = wrap_sub(TICK_W'(t + m - start), m);
        in_window = rel < len;
    endfunction

    // Register file
    logic duty_fix_reg;
    logic high_range_reg;
    logic [DIV_W-1:0] divide_ratio_setting_reg;
    logic [RATIO_W-1:0] mult_reg;
    logic [RATIO_W-1:0] div_ratio_reg;
    logic signed [SHIFT_W-1:0] fine_shift_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // Reference measurement
    logic ref_q_reg;
    logic ref_rise;
    logic [PER_W-1:0] cnt_reg;
    logic [PER_W-1:0] period_reg;
    logic [PER_W-1:0] high_cnt_reg;
    logic [PER_W-1:0] high_reg;
    logic locked_reg;

    // Phase arithmetic
    logic [PER_W-1:0] pos;
    logic [FRAC_BITS-1:0] shift_eff;
    logic [TICK_W-1:0] shift_prod_reg;
    logic [TICK_W-1:0] t_raw;
    logic [TICK_W-1:0] span;
    logic [TICK_W-1:0] qlen;
    logic [TICK_W-1:0] hlen;
    logic [TICK_W-1:0] tp;
    logic [TICK_W-1:0] high_len;
    logic [TICK_W-1:0] quad_len;
    logic [TICK_W-1:0] dr_rel;
    logic [1:0] qidx;
    logic [1:0] qidx_reg;
    logic period_wrap;

    // Synthesizer
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_sum;
    logic [ACC_W-1:0] synth_span;
    logic [ACC_W-1:0] synth_step;
    logic [RATIO_W-1:0] dcnt_reg;
    logic [RATIO_W-1:0] mult_eff;
    logic [RATIO_W-1:0] dratio_eff;

    // Output flops
    logic q000_reg;
    logic q090_reg;
    logic q180_reg;
    logic q270_reg;
    logic dr_reg;
    logic dr_inv_reg;
    logic synth_reg;
    logic synth_inv_reg;

    logic apb_setup_done;
    logic apb_commit;
    logic addr_hit;

    cocond_phase_if link ();

    assign apb_setup_done = psel && penable && !pready_reg;
    assign apb_commit = psel && penable && pready_reg;

    always_comb begin
        addr_hit = (paddr == OFF_CTRL) || (paddr == OFF_DIVIDE) || (paddr == OFF_SYNTH) ||
                   (paddr == OFF_SHIFT) || (paddr == OFF_STEP) || (paddr == OFF_STATUS);
    end

    // APB answer after one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            if (apb_setup_done) begin
                pready_reg <= 1'b1;
                pslverr_reg <= !addr_hit;
                prdata_reg <= 32'h00000000;
                if (!pwrite) begin
                    unique case (paddr)
                        OFF_CTRL: begin
                            prdata_reg[CTRL_DUTY_FIX_BIT] <= duty_fix_reg;
                            prdata_reg[CTRL_HIGH_RANGE_BIT] <= high_range_reg;
                        end
                        OFF_DIVIDE: begin
                            prdata_reg[DIV_W-1:0] <= divide_ratio_setting_reg;
                        end
                        OFF_SYNTH: begin
                            prdata_reg[SYNTH_MULT_LSB +: RATIO_W] <= mult_reg;
                            prdata_reg[SYNTH_DIV_LSB +: RATIO_W] <= div_ratio_reg;
                        end
                        OFF_SHIFT: begin
                            prdata_reg[SHIFT_W-1:0] <= fine_shift_reg;
                        end
                        OFF_STATUS: begin
                            prdata_reg[STAT_LOCKED_BIT] <= locked_reg;
                            prdata_reg[STAT_LEVEL_LSB +: 8] <= {synth_inv_reg, synth_reg,
                                link.divided, dr_inv_reg, dr_reg, q270_reg, q180_reg, q000_reg};
                            prdata_reg[STAT_PERIOD_LSB +: PER_W] <= period_reg;
                        end
                        default: begin
                            prdata_reg <= 32'h00000000;
                        end
                    endcase
                end
            end else begin
                pready_reg <= 1'b0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // Settings change at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_fix_reg <= CTRL_DUTY_FIX_RST;
            high_range_reg <= CTRL_HIGH_RANGE_RST;
            divide_ratio_setting_reg <= DIVIDE_RST;
            mult_reg <= MULT_RST;
            div_ratio_reg <= DIV_RATIO_RST;
        end else if (clk_en && apb_commit && pwrite) begin
            if (paddr == OFF_CTRL) begin
                duty_fix_reg <= pwdata[CTRL_DUTY_FIX_BIT];
                high_range_reg <= pwdata[CTRL_HIGH_RANGE_BIT];
            end
            if (paddr == OFF_DIVIDE) begin
                divide_ratio_setting_reg <= pwdata[DIV_W-1:0];
            end
            if (paddr == OFF_SYNTH) begin
                mult_reg <= pwdata[SYNTH_MULT_LSB +: RATIO_W];
                div_ratio_reg <= pwdata[SYNTH_DIV_LSB +: RATIO_W];
            end
        end
    end

    // Fine shift: written value or saturating steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_shift_reg <= SHIFT_RST;
        end else if (clk_en && apb_commit && pwrite) begin
            if (paddr == OFF_SHIFT) begin
                fine_shift_reg <= pwdata[SHIFT_W-1:0];
            end else if (paddr == OFF_STEP) begin
                if (pwdata[STEP_INC_BIT] && !pwdata[STEP_DEC_BIT] &&
                    fine_shift_reg != SHIFT_MAX) begin
                    fine_shift_reg <= fine_shift_reg + 9'sh001;
                end else if (pwdata[STEP_DEC_BIT] && !pwdata[STEP_INC_BIT] &&
                             fine_shift_reg != SHIFT_MIN) begin
                    fine_shift_reg <= fine_shift_reg - 9'sh001;
                end
            end
        end
    end

    assign ref_rise = ref_clock_in && !ref_q_reg;

    // Reference period and high time measurement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q_reg <= 1'b0;
            cnt_reg <= 12'h000;
            period_reg <= 12'h000;
            high_cnt_reg <= 12'h000;
            high_reg <= 12'h000;
            locked_reg <= 1'b0;
        end else if (clk_en) begin
            ref_q_reg <= ref_clock_in;
            if (ref_rise) begin
                cnt_reg <= 12'h001;
                period_reg <= cnt_reg;
                high_reg <= high_cnt_reg;
                high_cnt_reg <= 12'h001;
                locked_reg <= (cnt_reg == period_reg) && (cnt_reg > 12'h001);
            end else begin
                if (cnt_reg != 12'hFFF) begin
                    cnt_reg <= cnt_reg + 12'h001;
                end else begin
                    locked_reg <= 1'b0;
                end
                if (ref_clock_in && high_cnt_reg != 12'hFFF) begin
                    high_cnt_reg <= high_cnt_reg + 12'h001;
                end
            end
        end
    end

    // Shifted time within the period in 1/256 cycle units
    always_comb begin
        if (ref_rise) begin
            pos = 12'h000;
        end else if (cnt_reg >= period_reg && period_reg != 12'h000) begin
            pos = period_reg - 12'h001;
        end else begin
            pos = cnt_reg;
        end
        shift_eff = fine_shift_reg[FRAC_BITS-1:0];
        t_raw = TICK_W'({pos, {FRAC_BITS{1'b0}}});
        span = TICK_W'({period_reg, {FRAC_BITS{1'b0}}});
        qlen = TICK_W'({period_reg, {QUARTER_BITS{1'b0}}});
        hlen = TICK_W'({qlen, 1'b0});
        tp = wrap_sub(TICK_W'(t_raw + span - shift_prod_reg), span);
        high_len = TICK_W'({high_reg, {FRAC_BITS{1'b0}}});
        if (duty_fix_reg) begin
            quad_len = hlen;
        end else if (high_len >= span) begin
            quad_len = TICK_W'(span - 21'h000001);
        end else begin
            quad_len = high_len;
        end
        dr_rel = wrap_sub(tp, hlen);
        if (tp >= TICK_W'(hlen + qlen)) begin
            qidx = 2'd3;
        end else if (tp >= hlen) begin
            qidx = 2'd2;
        end else if (tp >= qlen) begin
            qidx = 2'd1;
        end else begin
            qidx = 2'd0;
        end
        period_wrap = locked_reg && (qidx == 2'd0) && (qidx_reg == 2'd3);
    end

    // Negative shifts wrap to an equal advance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_prod_reg <= 21'h000000;
            qidx_reg <= 2'd0;
        end else if (clk_en) begin
            shift_prod_reg <= TICK_W'(shift_eff * period_reg);
            qidx_reg <= qidx;
        end
    end

    // Quadrant and double rate outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q000_reg <= 1'b0;
            q090_reg <= 1'b0;
            q180_reg <= 1'b0;
            q270_reg <= 1'b0;
            dr_reg <= 1'b0;
            dr_inv_reg <= 1'b0;
        end else if (clk_en) begin
            q000_reg <= locked_reg && in_window(tp, 21'h000000, quad_len, span);
            q180_reg <= locked_reg && in_window(tp, hlen, quad_len, span);
            q090_reg <= locked_reg && !high_range_reg &&
                        in_window(tp, qlen, quad_len, span);
            q270_reg <= locked_reg && !high_range_reg &&
                        in_window(tp, TICK_W'(hlen + qlen), quad_len, span);
            dr_reg <= locked_reg && !high_range_reg && (dr_rel < qlen);
            dr_inv_reg <= locked_reg && !high_range_reg &&
                          in_window(dr_rel, qlen, qlen, hlen);
        end
    end

    // Synthesizer: M periods per D reference periods
    always_comb begin
        mult_eff = (mult_reg == 6'h00) ? 6'h01 : mult_reg;
        dratio_eff = (div_ratio_reg == 6'h00) ? 6'h01 : div_ratio_reg;
        synth_span = (ACC_W'(period_reg) * dratio_eff) << FRAC_BITS;
        synth_step = ACC_W'({mult_eff, {FRAC_BITS{1'b0}}});
        acc_sum = ACC_W'(acc_reg + synth_step);
        if (acc_sum >= synth_span) begin
            acc_sum = ACC_W'(acc_sum - synth_span);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 27'h0000000;
            dcnt_reg <= 6'h00;
        end else if (clk_en) begin
            if (period_wrap && dcnt_reg >= dratio_eff - 6'h01) begin
                acc_reg <= 27'h0000000;
                dcnt_reg <= 6'h00;
            end else begin
                acc_reg <= acc_sum;
                if (period_wrap) begin
                    dcnt_reg <= dcnt_reg + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synth_reg <= 1'b0;
            synth_inv_reg <= 1'b0;
        end else if (clk_en) begin
            synth_reg <= locked_reg && (acc_reg < (synth_span >> 1));
            synth_inv_reg <= locked_reg && (acc_reg >= (synth_span >> 1));
        end
    end

    // Divided output stage
    assign link.quarter_tick = locked_reg && (qidx != qidx_reg);
    assign link.high_range = high_range_reg;
    assign link.div_halves = divide_ratio_setting_reg;

    cocond_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .link(link.div)
    );

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign quad_phase_000 = q000_reg;
    assign quad_phase_090 = q090_reg;
    assign quad_phase_180 = q180_reg;
    assign quad_phase_270 = q270_reg;
    assign double_rate_out = dr_reg;
    assign double_rate_out_inv = dr_inv_reg;
    assign divided_out = link.divided;
    assign synth_out = synth_reg;
    assign synth_out_inv = synth_inv_reg;
endmodule

// File: hw/cocond_pkg.sv
// Constants and register map of the clock output conditioning block
// Functional notes
// - With duty fix on, which is its reset value, the four quadrant outputs are high half a period.
// - With duty fix off, the quadrant outputs follow the measured reference high time.
// - In the high range only the 0 and 180 degree quadrant outputs run; 90 and 270 stay low.
// - In the low range the double rate pair runs at twice the reference rate with equal high and low times; in the high range it stays low.
// - The divided output is 50% in the low range, and in the high range only for whole ratios.
// - The synthesized pair is always conditioned to a 50% duty cycle.
// - The second output of each half-period pair rises exactly half a period after the first.
// - The 0 and 180 degree pair has the same frequency as the reference clock.
// - Quadrant outputs rise at 0, 90, 180 and 270 degrees of the reference period.
// - A fixed or dynamic fine shift in steps of 1/256 of a cycle moves every output together.
// - Half-period, quadrant and fine shifting work alone or combined on the same outputs.
package cocond_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PER_W = 12;
    localparam int TICK_W = 21;
    localparam int ACC_W = 27;
    localparam int DIV_W = 6;
    localparam int QC_W = 7;
    localparam int RATIO_W = 6;
    localparam int SHIFT_W = 9;
    localparam int FRAC_BITS = 8;
    localparam int QUARTER_BITS = 6;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_DIVIDE = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_SYNTH = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_SHIFT = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_STEP = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h014;

    localparam int CTRL_DUTY_FIX_BIT = 0;
    localparam int CTRL_HIGH_RANGE_BIT = 1;
    localparam int SYNTH_MULT_LSB = 0;
    localparam int SYNTH_DIV_LSB = 8;
    localparam int STEP_INC_BIT = 0;
    localparam int STEP_DEC_BIT = 1;
    localparam int STAT_LOCKED_BIT = 0;
    localparam int STAT_LEVEL_LSB = 8;
    localparam int STAT_PERIOD_LSB = 16;

    localparam logic CTRL_DUTY_FIX_RST = 1'b1;
    localparam logic CTRL_HIGH_RANGE_RST = 1'b0;
    localparam logic [DIV_W-1:0] DIVIDE_RST = 6'h04;
    localparam logic [DIV_W-1:0] DIVIDE_MIN = 6'h03;
    localparam logic [RATIO_W-1:0] MULT_RST = 6'h02;
    localparam logic [RATIO_W-1:0] DIV_RATIO_RST = 6'h01;
    localparam logic signed [SHIFT_W-1:0] SHIFT_RST = 9'h000;
    localparam logic signed [SHIFT_W-1:0] SHIFT_MAX = 9'h0FF;
    localparam logic signed [SHIFT_W-1:0] SHIFT_MIN = 9'h101;
endpackage

// File: hw/cocond_phase_if.sv
// Link between the phase generator and the divided output stage
`timescale 1ns/10ps
interface cocond_phase_if;
    logic quarter_tick;
    logic high_range;
    logic [cocond_pkg::DIV_W-1:0] div_halves;
    logic divided;

    modport gen (
        output quarter_tick,
        output high_range,
        output div_halves,
        input divided
    );
    modport div (
        input quarter_tick,
        input high_range,
        input div_halves,
        output divided
    );
endinterface

// File: hw/cocond_divider.sv
// Divided output counting reference quarter periods
`timescale 1ns/10ps
module cocond_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    cocond_phase_if.div link
);
    import cocond_pkg::*;

    logic [QC_W-1:0] qc_reg;
    logic [QC_W-1:0] qc_next;
    logic [QC_W-1:0] full_len;
    logic [QC_W-1:0] high_len;
    logic [DIV_W-1:0] halves;
    logic out_reg;

    always_comb begin
        halves = (link.div_halves < DIVIDE_MIN) ? DIVIDE_MIN : link.div_halves;
        full_len = {halves, 1'b0};
        if (link.high_range && halves[0]) begin
            high_len = QC_W'({1'b0, halves} + 7'h01);
        end else begin
            high_len = {1'b0, halves};
        end
        qc_next = (QC_W'(qc_reg + 7'h01) >= full_len) ? 7'h00 : QC_W'(qc_reg + 7'h01);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qc_reg <= 7'h00;
            out_reg <= 1'b0;
        end else if (clk_en && link.quarter_tick) begin
            qc_reg <= qc_next;
            out_reg <= qc_next < high_len;
        end
    end

    assign link.divided = out_reg;
endmodule

// File: verification/cocond_props.sv
// Port checker for the clock output conditioning block
`timescale 1ns/10ps
module cocond_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cocond_pkg::ADDR_W-1:0] paddr,
    input wire logic [cocond_pkg::DATA_W-1:0] pwdata,
    input wire logic [cocond_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic quad_phase_000,
    input wire logic quad_phase_090,
    input wire logic quad_phase_180,
    input wire logic quad_phase_270,
    input wire logic double_rate_out,
    input wire logic double_rate_out_inv,
    input wire logic synth_out,
    input wire logic synth_out_inv
);
    import cocond_pkg::*;
    logic duty_fix_reg;
    logic high_range_reg;
    logic [7:0] settle_reg;
    // Control copy and cycles since written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_fix_reg <= CTRL_DUTY_FIX_RST;
            high_range_reg <= CTRL_HIGH_RANGE_RST;
            settle_reg <= 8'h00;
        end else if (clk_en && psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
            duty_fix_reg <= pwdata[CTRL_DUTY_FIX_BIT];
            high_range_reg <= pwdata[CTRL_HIGH_RANGE_BIT];
            settle_reg <= 8'h00;
        end else if (clk_en && settle_reg != 8'hFF) begin
            settle_reg <= settle_reg + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_access_a: assert property (psel && penable && !pready && clk_en |=> pready)
        else $error("no pready after access");
    ready_one_cycle_a: assert property (pready && clk_en |=> !pready)
        else $error("pready too long");
    unmapped_err_a: assert property (pready && paddr > OFF_STATUS |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr <= OFF_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    high_quad_quiet_a: assert property (
        high_range_reg && settle_reg > 8'h08 |-> !quad_phase_090 && !quad_phase_270)
        else $error("quadrant output in high range");
    high_double_quiet_a: assert property (
        high_range_reg && settle_reg > 8'h08 |-> !double_rate_out && !double_rate_out_inv)
        else $error("double rate output in high range");
    quad_halves_a: assert property (
        duty_fix_reg && settle_reg > 8'h40 |-> !(quad_phase_000 && quad_phase_180))
        else $error("quadrant pair overlaps");
    synth_pair_a: assert property (!(synth_out && synth_out_inv))
        else $error("synth pair overlaps");
    double_pair_a: assert property (
        !high_range_reg && settle_reg > 8'h40 |-> !(double_rate_out && double_rate_out_inv))
        else $error("double rate pair overlaps");
    cover property (pready && pslverr);
    cover property (high_range_reg && settle_reg == 8'h20);
    cover property ($rose(synth_out_inv));
endmodule
bind cocond_top cocond_props i_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .quad_phase_000(quad_phase_000), .quad_phase_090(quad_phase_090),
    .quad_phase_180(quad_phase_180), .quad_phase_270(quad_phase_270),
    .double_rate_out(double_rate_out), .double_rate_out_inv(double_rate_out_inv),
    .synth_out(synth_out), .synth_out_inv(synth_out_inv));

// File: verification/cocond_sink.sv
// User logic model that times every clock output
`timescale 1ns/10ps
module cocond_sink (
    input wire logic pclk,
    input wire logic [9:0] lines
);
    logic [9:0] last_reg = 10'h000;
    logic [31:0] now_reg = 32'h00000000;
    logic [31:0] edge_at [10];
    logic [31:0] hi_len [10];
    logic [31:0] lo_len [10];
    logic [31:0] rise_at [10];
    logic ddr_second = 1'b0;
    // Run lengths and last rise per line
    always @(posedge pclk) begin
        now_reg <= now_reg + 32'h1;
        last_reg <= lines;
        for (int i = 0; i < 10; i++) begin
            if (lines[i] && !last_reg[i]) begin
                rise_at[i] <= now_reg;
                lo_len[i] <= now_reg - edge_at[i];
                edge_at[i] <= now_reg;
            end else if (!lines[i] && last_reg[i]) begin
                hi_len[i] <= now_reg - edge_at[i];
                edge_at[i] <= now_reg;
            end
        end
        // Second DDR capture edge comes from the 180 degree output
        if (lines[2] && !last_reg[2]) ddr_second <= lines[0];
    end
endmodule

// File: verification/cocond_tb_top.sv
// Self-checking testbench of the clock output conditioning block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module cocond_tb_top;
    import cocond_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_clock_in = 1'b0;
    logic [7:0] ref_cnt = 8'h00;
    wire [9:0] lines;
    logic [DATA_W-1:0] rd;
    logic er;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 pclk = ~pclk;
    // Reference of 16 cycles, high for 6
    always @(posedge pclk) begin
        ref_cnt <= (ref_cnt == 8'h0F) ? 8'h00 : ref_cnt + 8'h01;
        ref_clock_in <= (ref_cnt < 8'h06);
    end
    assign lines[9] = ref_clock_in;
    cocond_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clock_in(ref_clock_in),
        .quad_phase_000(lines[0]), .quad_phase_090(lines[1]), .quad_phase_180(lines[2]),
        .quad_phase_270(lines[3]), .double_rate_out(lines[4]), .double_rate_out_inv(lines[5]),
        .divided_out(lines[6]), .synth_out(lines[7]), .synth_out_inv(lines[8]));
    cocond_sink u_sink (.pclk(pclk), .lines(lines));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK("register", ex, rd)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic duty(input int i, input logic [31:0] h, input logic [31:0] l);
        `CHK("high time", h, u_sink.hi_len[i])
        `CHK("low time", l, u_sink.lo_len[i])
    endtask
    function automatic logic [31:0] ph(input int a, input int b, input logic [31:0] m);
        return (u_sink.rise_at[a] - u_sink.rise_at[b]) % m;
    endfunction
    task automatic t_regs();
        rchk(OFF_CTRL, 32'h1);
        rchk(OFF_DIVIDE, 32'h4);
        rchk(OFF_SYNTH, 32'h102);
        rchk(OFF_SHIFT, 32'h0);
        rchk(OFF_STEP, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        `CHK("refusal", 33'h100000000, {er, rd})
        apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
        `CHK("status write error", 1'b0, er)
        do apb(1'b0, OFF_STATUS, 32'h0); while (rd[0] !== 1'b1);
        `CHK("period", 12'h010, rd[27:16])
        $display("test registers done");
    endtask
    task automatic t_low();
        idle(100);
        duty(0, 32'h8, 32'h8);
        duty(1, 32'h8, 32'h8);
        duty(3, 32'h8, 32'h8);
        `CHK("q090 phase", 32'h4, ph(1, 0, 32'h10))
        `CHK("q180 phase", 32'h8, ph(2, 0, 32'h10))
        `CHK("q270 phase", 32'hC, ph(3, 0, 32'h10))
        duty(4, 32'h4, 32'h4);
        `CHK("double pair phase", 32'h4, ph(5, 4, 32'h8))
        duty(6, 32'h10, 32'h10);
        duty(7, 32'h4, 32'h4);
        duty(8, 32'h4, 32'h4);
        `CHK("synth pair phase", 32'h4, ph(8, 7, 32'h8))
        `CHK("ddr second edge", 1'b0, u_sink.ddr_second)
        apb(1'b1, OFF_CTRL, 32'h0);
        idle(100);
        duty(0, 32'h6, 32'hA);
        duty(2, 32'h6, 32'hA);
        `CHK("q090 phase", 32'h4, ph(1, 0, 32'h10))
        duty(4, 32'h4, 32'h4);
        duty(7, 32'h4, 32'h4);
        $display("test low range done");
    endtask
    task automatic t_high();
        logic seen;
        apb(1'b1, OFF_CTRL, 32'h3);
        idle(20);
        seen = 1'b0;
        repeat (64) begin
            @(posedge pclk);
            seen = seen | lines[1] | lines[3] | lines[4] | lines[5];
        end
        `CHK("quiet outputs", 1'b0, seen)
        duty(0, 32'h8, 32'h8);
        `CHK("q180 phase", 32'h8, ph(2, 0, 32'h10))
        apb(1'b1, OFF_DIVIDE, 32'h5);
        idle(150);
        duty(6, 32'h18, 32'h10);
        apb(1'b1, OFF_DIVIDE, 32'h6);
        idle(150);
        duty(6, 32'h18, 32'h18);
        apb(1'b1, OFF_CTRL, 32'h1);
        apb(1'b1, OFF_DIVIDE, 32'h5);
        idle(150);
        duty(6, 32'h14, 32'h14);
        apb(1'b1, OFF_DIVIDE, 32'h1);
        idle(150);
        duty(6, 32'hC, 32'hC);
        apb(1'b1, OFF_DIVIDE, 32'h4);
        $display("test high range done");
    endtask
    task automatic t_shift();
        logic [31:0] b0, b4, b7;
        b0 = ph(0, 9, 32'h10);
        b4 = ph(4, 9, 32'h8);
        b7 = ph(7, 9, 32'h8);
        apb(1'b1, OFF_SHIFT, 32'h40);
        idle(150);
        `CHK("q000 shift", (b0 + 32'h4) % 32'h10, ph(0, 9, 32'h10))
        `CHK("double shift", (b4 + 32'h4) % 32'h8, ph(4, 9, 32'h8))
        `CHK("synth shift", (b7 + 32'h4) % 32'h8, ph(7, 9, 32'h8))
        `CHK("q090 phase", 32'h4, ph(1, 0, 32'h10))
        duty(0, 32'h8, 32'h8);
        apb(1'b1, OFF_STEP, 32'h1);
        rchk(OFF_SHIFT, 32'h41);
        apb(1'b1, OFF_STEP, 32'h3);
        rchk(OFF_SHIFT, 32'h41);
        apb(1'b1, OFF_STEP, 32'h2);
        rchk(OFF_SHIFT, 32'h40);
        apb(1'b1, OFF_SHIFT, 32'hFF);
        apb(1'b1, OFF_STEP, 32'h1);
        rchk(OFF_SHIFT, 32'hFF);
        apb(1'b1, OFF_SHIFT, 32'h101);
        apb(1'b1, OFF_STEP, 32'h2);
        rchk(OFF_SHIFT, 32'h101);
        apb(1'b1, OFF_SHIFT, 32'h0);
        $display("test fine shift done");
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_low();
        t_high();
        t_shift();
        complete_run();
    end
endmodule
